/* File: dpsev_pkg.sv */
// package of offsets, field positions, reset values and encodings for the loop status bank
// assumes a 32-bit axi4-lite register bus, one aligned word per register
package dpsev_pkg;
    localparam logic [7:0] addr_trim = 8'h00;
    localparam logic [7:0] addr_status = 8'h04;
    localparam logic [7:0] addr_events = 8'h08;
    localparam logic [7:0] addr_lol_cnt = 8'h0c;
    localparam logic [7:0] addr_irq_mask = 8'h10;
    localparam logic [7:0] trim_reset = 8'h1f;
    localparam logic [3:0] events_reset = 4'h0;
    localparam logic [3:0] lol_cnt_reset = 4'h0;
    localparam logic [3:0] lol_cnt_max = 4'hf;
    localparam logic [3:0] mask_reset = 4'h0;
    localparam int state_lsb = 4;
    localparam int ref_sel_bit = 1;
    localparam int lock_bit = 0;
    localparam int ev_state_ch = 3;
    localparam int ev_holdover = 2;
    localparam int ev_lol_lmt = 1;
    localparam int ev_lol = 0;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    typedef enum logic [2:0] {
        dpsev_freerun = 3'h0,
        dpsev_normal = 3'h1,
        dpsev_holdover = 3'h2,
        dpsev_write_freq = 3'h3,
        dpsev_acquire = 3'h4,
        dpsev_hitless = 3'h5
    } dpsev_state_e;
endpackage

/* File: dpsev_regs.sv */
// loop status, event flags, lock-loss counter and delay trim behind axi4-lite
// assumes loop state, reference select and lock level arrive synchronous to aclk
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module dpsev_regs #(
    parameter logic [3:0] lol_cnt_thresh = 4'h8
)(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // loop side
    input wire logic [2:0] loop_state,
    input wire logic ref_select,
    input wire logic lock_detect,
    input wire logic loop_clock_gated,
    input wire logic loop_soft_reset,
    // outputs to the loop and interrupt
    output logic [7:0] delay_trim,
    output logic irq
);

    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic [7:0] trim_q;
    logic [3:0] events_q;
    logic [3:0] mask_q;
    logic [3:0] lol_cnt_q;
    logic [2:0] state_q;
    logic ref_q;
    logic lock_q;
    logic started_q;
    logic irq_q;
    logic do_write;
    logic wr_lane0;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic over_thresh;
    logic [31:0] rd_d;
    logic rd_ok;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic cnt_open;
    logic wr_sel_trim;
    logic wr_sel_events;
    logic wr_sel_cnt;
    logic wr_sel_mask;
    logic wr_known;

    // write address and data captured independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held_q <= 1'b0;
        end
    end

    // channel takes and the single write strobe
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0 = do_write && wstrb_q[0];
    assign cnt_open = !loop_clock_gated && !loop_soft_reset;

    // write target decode from the held address
    always_comb
    begin
        wr_sel_trim = 1'b0;
        wr_sel_events = 1'b0;
        wr_sel_cnt = 1'b0;
        wr_sel_mask = 1'b0;
        wr_known = 1'b1;
        case (awaddr_q[7:2])
            dpsev_pkg::addr_trim[7:2]: wr_sel_trim = wr_lane0;
            dpsev_pkg::addr_status[7:2]: wr_known = 1'b1;
            dpsev_pkg::addr_events[7:2]: wr_sel_events = wr_lane0;
            dpsev_pkg::addr_lol_cnt[7:2]: wr_sel_cnt = wr_lane0;
            dpsev_pkg::addr_irq_mask[7:2]: wr_sel_mask = wr_lane0;
            default: wr_known = 1'b0;
        endcase
    end

    // ready drops the cycle after a take and stays low while that beat is held or a response is pending
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_awready <= 1'b0;
        else
            s_axi_awready <= !aw_held_q && !aw_take && !s_axi_bvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_wready <= 1'b0;
        else
            s_axi_wready <= !w_held_q && !w_take && !s_axi_bvalid;
    end

    // response two cycles after the later of address and data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bvalid <= 1'b0;
        else if (do_write)
            s_axi_bvalid <= 1'b1;
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bresp <= dpsev_pkg::resp_okay;
        else if (do_write)
            s_axi_bresp <= wr_known ? dpsev_pkg::resp_okay : dpsev_pkg::resp_slverr;
    end

    // debug delay trim toward the phase detector path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            trim_q <= dpsev_pkg::trim_reset;
        else if (wr_sel_trim)
            trim_q <= wdata_q[7:0];
    end

    // sampled loop status, one cycle behind the loop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= dpsev_pkg::dpsev_freerun;
        else
            state_q <= loop_state;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ref_q <= 1'b0;
        else
            ref_q <= ref_select;
    end

    // lock level is owned by the loop's lock detector
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lock_q <= 1'b0;
        else
            lock_q <= lock_detect;
    end

    // masks false events on the first cycle out of reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            started_q <= 1'b0;
        else
            started_q <= 1'b1;
    end

    // alarm compare against the fixed threshold
    assign over_thresh = lol_cnt_q > lol_cnt_thresh;
    assign ev_clr = wr_sel_events ? wdata_q[3:0] : 4'h0;

    // event sources
    always_comb
    begin
        ev_set = 4'h0;
        if (started_q)
        begin
            ev_set[dpsev_pkg::ev_state_ch] = loop_state != state_q;
            ev_set[dpsev_pkg::ev_holdover] = loop_state == dpsev_pkg::dpsev_holdover
                && state_q != dpsev_pkg::dpsev_holdover;
            ev_set[dpsev_pkg::ev_lol] = lock_q && !lock_detect;
        end
        ev_set[dpsev_pkg::ev_lol_lmt] = over_thresh;
    end

    // sticky flags, one per event; a set in the clearing cycle wins
    for (genvar b = 0; b < 4; b++)
    begin : g_event
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                events_q[b] <= dpsev_pkg::events_reset[b];
            else if (ev_set[b])
                events_q[b] <= 1'b1;
            else if (ev_clr[b])
                events_q[b] <= 1'b0;
        end
    end

    // lock-loss counter with guarded software preset; a write beats a count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lol_cnt_q <= dpsev_pkg::lol_cnt_reset;
        else if (wr_sel_cnt && cnt_open)
            lol_cnt_q <= wdata_q[3:0];
        else if (ev_set[dpsev_pkg::ev_lol] && lol_cnt_q != dpsev_pkg::lol_cnt_max)
            lol_cnt_q <= lol_cnt_q + 4'h1;
    end

    // interrupt mask, same layout as the event flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask_q <= dpsev_pkg::mask_reset;
        else if (wr_sel_mask)
            mask_q <= wdata_q[3:0];
    end

    // level interrupt from unmasked flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(events_q & mask_q);
    end

    // read decode, reserved bits zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr[7:2])
            dpsev_pkg::addr_trim[7:2]: rd_d[7:0] = trim_q;
            dpsev_pkg::addr_status[7:2]: rd_d[6:0] = {state_q, 2'h0, ref_q, lock_q};
            dpsev_pkg::addr_events[7:2]: rd_d[3:0] = events_q;
            dpsev_pkg::addr_lol_cnt[7:2]: rd_d[3:0] = lol_cnt_q;
            dpsev_pkg::addr_irq_mask[7:2]: rd_d[3:0] = mask_q;
            default: rd_ok = 1'b0;
        endcase
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_arready <= 1'b0;
        else if (ar_take)
            s_axi_arready <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_rvalid <= 1'b0;
        else if (ar_take)
            s_axi_rvalid <= 1'b1;
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // read data captured with the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dpsev_pkg::resp_okay;
        end
        else if (ar_take)
        begin
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? dpsev_pkg::resp_okay : dpsev_pkg::resp_slverr;
        end
    end

    // outputs straight from their flops
    assign delay_trim = trim_q;
    assign irq = irq_q;
endmodule

/* File: dpsev_regs_properties.sv */
// bus timing, reserved bits and trim checks for the loop status bank
// bound to dpsev_regs from the bench top file
module dpsev_regs_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // loop side
    input wire logic [7:0] delay_trim
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ar_q;
    logic [7:0] wd_q;
    always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    always_ff @(posedge aclk) if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    trim_rst_a: assert property ($rose(aresetn) |-> delay_trim == 8'h1f)
        else $error("trim not at reset value");
    trim_write_a: assert property (wr_taken_s ##0 (s_axi_awaddr == 8'h00 && s_axi_wstrb[0])
        |-> ##3 delay_trim == wd_q) else $error("trim write lost");
    status_rsv_a: assert property (s_axi_rvalid && ar_q == 8'h04 |->
        s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[3:2] == 2'h0) else $error("status reserved set");
    event_rsv_a: assert property (s_axi_rvalid && ar_q == 8'h08 |-> s_axi_rdata[31:4] == 28'h0)
        else $error("event reserved set");
    cnt_rsv_a: assert property (s_axi_rvalid && ar_q == 8'h0c |-> s_axi_rdata[31:4] == 28'h0)
        else $error("counter reserved set");
    unmapped_read_a: assert property (s_axi_rvalid && ar_q[7:2] > 6'h04 |->
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (wr_taken_s |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer off time");
endmodule

/* File: dpsev_regs_tb_top.sv */
// bench for the loop status bank: bus tasks, loop stimulus, self checks
// assumes design, package and checker are compiled first
module dpsev_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr, araddr, trim;
    logic [31:0] wdata, rdata, rd_d;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [2:0] loop_state;
    logic ref_sel, lock, gated, srst, irq;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    always #50 aclk = ~aclk;
    dpsev_regs #(.lol_cnt_thresh(4'h8)) dpsev_regs_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .loop_state(loop_state), .ref_select(ref_sel), .lock_detect(lock),
        .loop_clock_gated(gated), .loop_soft_reset(srst), .delay_trim(trim), .irq(irq));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        pa = 1;
        pw = 1;
        while (pa || pw)
        begin
            @(posedge aclk);
            pa = pa && awready !== 1'b1;
            pw = pw && wready !== 1'b1;
            {awvalid, wvalid} <= {pa, pw};
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        wr_r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_d, e);
    endtask
    task automatic fall(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            lock <= 1;
            repeat (3) @(posedge aclk);
            lock <= 0;
            repeat (2) @(posedge aclk);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_regs;
        rc(8'h00, 32'h1f);
        chk({24'h0, trim}, 32'h1f);
        rc(8'h04, 32'h0);
        rc(8'h08, 32'h0);
        rc(8'h0c, 32'h0);
        wr(8'h00, 32'hffff_ff5a);
        rc(8'h00, 32'h5a);
        chk({24'h0, trim}, 32'h5a);
        wstrb <= 4'he;
        wr(8'h00, 32'h33);
        wstrb <= 4'hf;
        chk({30'h0, wr_r}, 32'h0);
        rc(8'h00, 32'h5a);
        wr(8'h04, 32'h7f);
        rc(8'h04, 32'h0);
        wr(8'h20, 32'h0);
        chk({30'h0, wr_r}, 32'h2);
        rd(8'h20);
        chk({30'h0, rd_r}, 32'h2);
    endtask
    task automatic t_state;
        logic [2:0] s;
        lock <= 1;
        for (int i = 1; i < 7; i++)
        begin
            s = 3'(i % 6);
            loop_state <= s;
            ref_sel <= s[0];
            repeat (3) @(posedge aclk);
            rc(8'h04, {25'h0, s, 2'h0, s[0], 1'b1});
            rc(8'h08, {28'h0, 1'b1, s == 3'h2, 2'h0});
            wr(8'h08, 32'hf);
            rc(8'h08, 32'h0);
        end
    endtask
    task automatic t_lol;
        wr(8'h10, 32'h1);
        fall(1);
        rc(8'h08, 32'h1);
        rc(8'h0c, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(8'h08, 32'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        fall(8);
        rc(8'h0c, 32'h9);
        wr(8'h08, 32'h3);
        rc(8'h08, 32'h2);
        fall(7);
        rc(8'h0c, 32'hf);
        wr(8'h0c, 32'h0);
        wr(8'h08, 32'h3);
        rc(8'h08, 32'h0);
        wr(8'h0c, 32'h9);
        rc(8'h08, 32'h2);
    endtask
    task automatic t_gate;
        gated <= 1;
        wr(8'h0c, 32'h5);
        rc(8'h0c, 32'h9);
        gated <= 0;
        srst <= 1;
        wr(8'h0c, 32'h5);
        rc(8'h0c, 32'h9);
        srst <= 0;
        wr(8'h0c, 32'h5);
        rc(8'h0c, 32'h5);
    endtask
    initial
    begin
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {loop_state, ref_sel, lock, gated, srst} = 7'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_state;
        t_lol;
        t_gate;
        wrap_up;
    end
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            wrap_up;
        end
    end
endmodule
bind dpsev_regs dpsev_regs_properties dpsev_regs_properties_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .delay_trim(delay_trim));
